// ---- common/pxp_pkg.sv ----
// constants, codes and types for the parallel pixel port host controller
// assumes a single 20 MHz core clock; all times become cycle counts here
package pxp_pkg;

  // bus width codes, equal to the levels driven on the four straps
  localparam logic [3:0] BUS_W8    = 4'h0;
  localparam logic [3:0] BUS_W9    = 4'h1;
  localparam logic [3:0] BUS_W16   = 4'h2;
  localparam logic [3:0] BUS_W18   = 4'h3;
  localparam logic [3:0] BUS_W24   = 4'h4;
  localparam logic [3:0] BUS_RESET = 4'h0;

  // pixel format parameter values
  localparam logic [2:0] FMT_65K   = 3'h5;
  localparam logic [2:0] FMT_262K  = 3'h6;
  localparam logic [2:0] FMT_16M   = 3'h7;
  localparam logic [2:0] FMT_RESET = 3'h7;

  // command codes the controller tracks
  localparam logic [7:0] CMD_MEM_WRITE  = 8'h2c;
  localparam logic [7:0] CMD_MEM_READ   = 8'h2e;
  localparam logic [7:0] CMD_PIX_FORMAT = 8'h3a;
  localparam logic [7:0] CMD_ST_DA      = 8'hda;
  localparam logic [7:0] CMD_ST_DB      = 8'hdb;
  localparam logic [7:0] CMD_ST_DC      = 8'hdc;
  localparam logic [7:0] CMD_ST_04      = 8'h04;
  localparam logic [7:0] CMD_ST_09      = 8'h09;
  localparam logic [7:0] CMD_ST_LO      = 8'h0a;
  localparam logic [7:0] CMD_ST_HI      = 8'h0f;

  // strobe timing, in ns and in 50 ns core cycles (least times round up)
  localparam int CORE_MHZ     = 20;
  localparam int T_WR_LOW_NS  = 30;
  localparam int T_HOLD_NS    = 30;
  localparam int T_RD_LOW_NS  = 250;
  localparam int WR_LOW_CYC   = (T_WR_LOW_NS * CORE_MHZ + 999) / 1000;
  localparam int HOLD_CYC     = (T_HOLD_NS * CORE_MHZ + 999) / 1000;
  localparam int RD_LOW_CYC   = (T_RD_LOW_NS * CORE_MHZ + 999) / 1000;
  localparam logic [2:0] WR_LOW_LOAD = 3'(WR_LOW_CYC - 1);
  localparam logic [2:0] HOLD_LOAD   = 3'(HOLD_CYC - 1);
  localparam logic [2:0] RD_LOW_LOAD = 3'(RD_LOW_CYC - 1);

  // buffering and bus sizes
  localparam int PIX_W      = 24;
  localparam int BUS_W      = 24;
  localparam int FIFO_DEPTH = 8;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_SETUP = 3'b001,
    ST_WLOW  = 3'b010,
    ST_RLOW  = 3'b011,
    ST_HOLD  = 3'b100
  } pxp_state_t;

  typedef enum logic [1:0] {
    MODE_REG = 2'b00,
    MODE_WR  = 2'b01,
    MODE_RD  = 2'b10,
    MODE_FMT = 2'b11
  } pxp_mode_t;

endpackage

// ---- rtl/pxp_host.sv ----
// host controller for an 8080-style parallel pixel port, with pixel fifo
// assumes one 20 MHz clock; read data from the pins arrives asynchronously
`timescale 1ns/100ps
`default_nettype none

// simple synchronous fifo; depth must be a power of two
module pxp_fifo #(
  parameter int W = 24,
  parameter int D = 8
) (
  input  wire logic         i_core_clk,
  input  wire logic         i_reset,
  input  wire logic         i_valid,
  input  wire logic [W-1:0] i_data,
  output logic              o_ready,
  output logic              o_valid,
  output logic [W-1:0]      o_data,
  input  wire logic         i_ready
);
  localparam int AW = $clog2(D);
  logic [W-1:0]  mem [D];     // storage
  logic [AW-1:0] wptr;        // write pointer, wraps naturally
  logic [AW-1:0] rptr;        // read pointer
  logic [AW:0]   count;       // words held
  logic [AW:0]   next_count;
  wire           push = i_valid && o_ready;
  wire           pop  = o_valid && i_ready;

  assign o_valid    = (count != '0);
  assign o_data     = mem[rptr];
  assign next_count = count + (AW+1)'(push) - (AW+1)'(pop);

  // storage is not reset, only the pointers, count and ready are
  always_ff @(posedge i_core_clk) begin
    if (push) begin
      mem[wptr] <= i_data;
    end
  end

  // pointers, count and a registered full flag for the ready
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      wptr    <= '0;
      rptr    <= '0;
      count   <= '0;
      o_ready <= 1'b0;
    end else begin
      wptr    <= wptr + AW'(push);
      rptr    <= rptr + AW'(pop);
      count   <= next_count;
      o_ready <= (next_count != (AW+1)'(D));
    end
  end
endmodule

module pxp_host (
  input  wire logic                       i_core_clk,
  input  wire logic                       i_reset,
  input  wire logic [3:0]                 i_bus_code,
  input  wire logic                       i_cmd_valid,
  input  wire logic                       i_cmd_dc,
  input  wire logic                       i_cmd_read,
  input  wire logic [7:0]                 i_cmd_data,
  output logic                            o_cmd_ready,
  input  wire logic                       i_pix_valid,
  input  wire logic [pxp_pkg::PIX_W-1:0]  i_pix_data,
  output logic                            o_pix_ready,
  output logic                            o_rd_valid,
  output logic [7:0]                      o_rd_data,
  output logic                            o_rd_status,
  output logic                            o_rpix_valid,
  output logic [pxp_pkg::PIX_W-1:0]       o_rpix_data,
  output logic                            o_fmt_error,
  output logic                            o_port_select_n,
  output logic                            o_write_strobe_n,
  output logic                            o_read_strobe_n,
  output logic                            o_data_command_select,
  output logic [pxp_pkg::BUS_W-1:0]       o_data,
  output logic                            o_data_oe,
  input  wire logic [pxp_pkg::BUS_W-1:0]  i_data,
  output logic                            o_bus_select_strap3,
  output logic                            o_bus_select_strap2,
  output logic                            o_bus_select_strap1,
  output logic                            o_bus_select_strap0
);
  import pxp_pkg::*;

  pxp_state_t  state, next_state;   // strobe sequencer
  pxp_mode_t   mode;                // what the last command opened
  logic [2:0]  cnt, next_cnt;       // phase length counter
  logic [1:0]  phase, next_phase;   // transfer index inside a pixel group
  logic [3:0]  width;               // bus width code, mirrors the straps
  logic [2:0]  fmt;                 // current pixel format
  logic [7:0]  last_cmd;            // last command code written
  logic        cur_read;            // transfer in flight is a read
  logic [23:0] pix_a, pix_b;        // pixels held across a group
  logic [23:0] racc, next_racc;     // partial pixel on memory read
  logic [23:0] data_s1, data_s2;    // read data synchroniser
  logic        take_cmd, take_pix;  // transfer start strobes
  logic        rpix_emit;           // a read pixel is complete
  logic [23:0] rpix_word;

  // fifo between the pixel source and the strobe engine
  logic        fifo_valid;
  logic [23:0] fifo_data;
  wire         fifo_pop;

  pxp_fifo #(.W(PIX_W), .D(FIFO_DEPTH)) u_fifo (
    .i_core_clk (i_core_clk),
    .i_reset    (i_reset),
    .i_valid    (i_pix_valid),
    .i_data     (i_pix_data),
    .o_ready    (o_pix_ready),
    .o_valid    (fifo_valid),
    .o_data     (fifo_data),
    .i_ready    (fifo_pop)
  );

  // index of the last transfer in one pixel group, per width and format
  function automatic logic [1:0] wr_last(input logic [3:0] w,
                                         input logic [2:0] f);
    if (w == BUS_W8) wr_last = (f == FMT_65K) ? 2'd1 : 2'd2;
    else if (w == BUS_W9) wr_last = (f == FMT_262K) ? 2'd1 : 2'd2;
    else if (w == BUS_W16) wr_last = (f == FMT_65K) ? 2'd0 : 2'd2;
    else if (w == BUS_W18) wr_last = (f == FMT_16M) ? 2'd2 : 2'd0;
    else wr_last = 2'd0;
  endfunction

  // bus word for one pixel write transfer; x first pixel, y second
  function automatic logic [23:0] pack_word(input logic [3:0]  w,
                                            input logic [2:0]  f,
                                            input logic [1:0]  ph,
                                            input logic [23:0] x,
                                            input logic [23:0] y);
    logic [7:0]  c;
    logic [23:0] w565, w666, two;
    c    = (ph == 2'd0) ? x[23:16] : (ph == 2'd1) ? x[15:8] : x[7:0];
    w565 = {8'h00, x[23:19], x[15:10], x[7:3]};
    w666 = {6'h00, x[23:18], x[15:10], x[7:2]};
    // two pixels in three transfers, 16.7M order R1G1 B1R2 G2B2
    two  = (ph == 2'd0) ? {8'h00, x[23:16], x[15:8]} :
           (ph == 2'd1) ? {8'h00, x[7:0], y[23:16]} :
                          {8'h00, y[15:8], y[7:0]};
    case (w)
      BUS_W8: begin
        if (f == FMT_65K)
          pack_word = (ph == 2'd0) ? {16'h0000, x[23:19], x[15:13]}
                                   : {16'h0000, x[12:10], x[7:3]};
        else if (f == FMT_262K)
          pack_word = {16'h0000, c[7:2], 2'b00};
        else
          pack_word = {16'h0000, c};
      end
      BUS_W9: begin
        if (f == FMT_262K)
          pack_word = (ph == 2'd0) ? {15'h0000, x[23:18], x[15:13]}
                                   : {15'h0000, x[12:10], x[7:2]};
        else
          pack_word = {15'h0000, c, 1'b0};
      end
      BUS_W16: begin
        if (f == FMT_65K)
          pack_word = w565;
        else if (f == FMT_262K)
          pack_word = (ph == 2'd0) ?
              {8'h00, x[23:18], 2'b00, x[15:10], 2'b00} :
            (ph == 2'd1) ? {8'h00, x[7:2], 2'b00, y[23:18], 2'b00} :
                           {8'h00, y[15:10], 2'b00, y[7:2], 2'b00};
        else
          pack_word = two;
      end
      BUS_W18: begin
        if (f == FMT_65K) pack_word = w565;
        else if (f == FMT_262K) pack_word = w666;
        else pack_word = two;
      end
      default: begin
        if (f == FMT_65K) pack_word = w565;
        else if (f == FMT_262K) pack_word = w666;
        else pack_word = {x[23:17], x[15:8], x[16], x[7:0]};
      end
    endcase
  endfunction

  // register and status read codes
  function automatic logic is_status(input logic [7:0] c);
    is_status = (c == CMD_ST_DA) || (c == CMD_ST_DB) || (c == CMD_ST_DC) ||
                (c == CMD_ST_04) || (c == CMD_ST_09) ||
                ((c >= CMD_ST_LO) && (c <= CMD_ST_HI));
  endfunction

  // decode of the pixel engine
  wire       two_px   = ((width == BUS_W16) && (fmt != FMT_65K)) ||
                        ((width == BUS_W18) && (fmt == FMT_16M));
  wire [1:0] wlast    = wr_last(width, fmt);
  wire [1:0] rlast    = (width == BUS_W24) ? 2'd0 : 2'd2;
  wire       need_pop = (phase == 2'd0) || ((phase == 2'd1) && two_px);
  // 65K has no 9-bit packing; unknown codes are refused the same way
  wire       fmt_bad  = ((width == BUS_W9) && (fmt == FMT_65K)) ||
                        (fmt < FMT_65K);
  wire       pix_go   = (mode == MODE_WR) && !fmt_bad &&
                        (fifo_valid || !need_pop);
  wire       rd_done  = (state == ST_RLOW) && (cnt == 3'd0);
  wire [23:0] px_x    = (phase == 2'd0) ? fifo_data : pix_a;
  wire [23:0] px_y    = (phase == 2'd1) ? fifo_data : pix_b;
  wire [23:0] pix_word = pack_word(width, fmt, phase, px_x, px_y);
  wire [23:0] cmd_word = {16'h0000, i_cmd_data};
  wire [7:0]  rd_comp  = (width == BUS_W9) ? data_s2[8:1]
                                           : data_s2[7:0];
  wire        next_read = take_cmd ? i_cmd_read :
                          take_pix ? 1'b0 : cur_read;
  assign fifo_pop = take_pix && need_pop;

  // strobe sequencer: setup, strobe low, hold with strobe high
  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    take_cmd   = 1'b0;
    take_pix   = 1'b0;
    case (state)
      ST_IDLE: begin
        if (i_cmd_valid && o_cmd_ready) begin
          take_cmd   = 1'b1;
          next_state = ST_SETUP;
        end else if (pix_go) begin
          take_pix   = 1'b1;
          next_state = ST_SETUP;
        end
      end
      ST_SETUP: begin
        next_state = cur_read ? ST_RLOW : ST_WLOW;
        next_cnt   = cur_read ? RD_LOW_LOAD : WR_LOW_LOAD;
      end
      ST_WLOW, ST_RLOW: begin
        if (cnt == 3'd0) begin
          next_state = ST_HOLD;
          next_cnt   = HOLD_LOAD;
        end else begin
          next_cnt = cnt - 3'd1;
        end
      end
      ST_HOLD: begin
        if (cnt == 3'd0) next_state = ST_IDLE;
        else next_cnt = cnt - 3'd1;
      end
      default: next_state = ST_IDLE;
    endcase
  end

  // group phase: commands restart it, pixels and memory reads advance it
  always_comb begin
    next_phase = phase;
    if (take_cmd && !i_cmd_dc && !i_cmd_read)
      next_phase = 2'd0;
    else if (take_pix)
      next_phase = (phase == wlast) ? 2'd0 : phase + 2'd1;
    else if (rd_done && (mode == MODE_RD))
      next_phase = (phase == rlast) ? 2'd0 : phase + 2'd1;
  end

  // memory read unpacking into 8-8-8 pixels
  always_comb begin
    next_racc = racc;
    rpix_emit = 1'b0;
    rpix_word = racc;
    if (width == BUS_W24) begin
      rpix_emit = 1'b1;
      rpix_word = {data_s2[23:17], data_s2[8], data_s2[16:9], data_s2[7:0]};
    end else if ((width == BUS_W16) || (width == BUS_W18)) begin
      if (phase == 2'd0) begin
        next_racc = {data_s2[15:0], 8'h00};
      end else if (phase == 2'd1) begin
        rpix_emit = 1'b1;
        rpix_word = {racc[23:8], data_s2[15:8]};
        next_racc = {data_s2[7:0], 16'h0000};
      end else begin
        rpix_emit = 1'b1;
        rpix_word = {racc[23:16], data_s2[15:0]};
      end
    end else begin
      if (phase == 2'd0) next_racc = {rd_comp, racc[15:0]};
      else if (phase == 2'd1) next_racc = {racc[23:16], rd_comp, racc[7:0]};
      else begin
        rpix_emit = 1'b1;
        rpix_word = {racc[23:8], rd_comp};
      end
    end
  end

  // read data comes from another chip: two flops before any use
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      data_s1 <= '0;
      data_s2 <= '0;
    end else begin
      data_s1 <= i_data;
      data_s2 <= data_s1;
    end
  end

  // sequencer state
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      state       <= ST_IDLE;
      cnt         <= 3'd0;
      phase       <= 2'd0;
      cur_read    <= 1'b0;
      o_cmd_ready <= 1'b0;
    end else begin
      state       <= next_state;
      cnt         <= next_cnt;
      phase       <= next_phase;
      cur_read    <= next_read;
      // commands wait until a pixel group is finished; a memory read
      // group stays open, since each of its reads is itself a request
      o_cmd_ready <= (next_state == ST_IDLE) &&
                     ((next_phase == 2'd0) || (mode == MODE_RD));
    end
  end

  // pins: select frames the strobe, data set up before it falls
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      o_port_select_n       <= 1'b1;
      o_write_strobe_n      <= 1'b1;
      o_read_strobe_n       <= 1'b1;
      o_data_command_select <= 1'b1;
      o_data_oe             <= 1'b0;
    end else begin
      o_port_select_n  <= (next_state == ST_IDLE);
      o_write_strobe_n <= (next_state != ST_WLOW);
      o_read_strobe_n  <= (next_state != ST_RLOW);
      o_data_oe        <= (next_state != ST_IDLE) && !next_read;
      if (take_cmd) o_data_command_select <= i_cmd_dc;
      else if (take_pix) o_data_command_select <= 1'b1;
    end
  end

  // data bus word; unused lines stay low
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) o_data <= '0;
    else if (take_cmd) o_data <= cmd_word;
    else if (take_pix) o_data <= pix_word;
  end

  // straps and pixel format tracking
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      width       <= BUS_RESET;
      fmt         <= FMT_RESET;
      o_fmt_error <= 1'b0;
    end else begin
      width       <= i_bus_code;
      o_fmt_error <= fmt_bad;
      if (take_cmd && i_cmd_dc && !i_cmd_read && (mode == MODE_FMT))
        fmt <= i_cmd_data[2:0];
    end
  end
  assign {o_bus_select_strap3, o_bus_select_strap2,
          o_bus_select_strap1, o_bus_select_strap0} = width;

  // command tracking
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      mode     <= MODE_REG;
      last_cmd <= 8'h00;
    end else if (take_cmd && !i_cmd_dc && !i_cmd_read) begin
      last_cmd <= i_cmd_data;
      if (i_cmd_data == CMD_MEM_WRITE) mode <= MODE_WR;
      else if (i_cmd_data == CMD_MEM_READ) mode <= MODE_RD;
      else if (i_cmd_data == CMD_PIX_FORMAT) mode <= MODE_FMT;
      else mode <= MODE_REG;
    end else if (take_cmd && (mode == MODE_FMT)) begin
      mode <= MODE_REG;
    end
  end

  // pixels held across a group
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      pix_a <= '0;
      pix_b <= '0;
    end else if (fifo_pop) begin
      if (phase == 2'd0) pix_a <= fifo_data;
      else pix_b <= fifo_data;
    end
  end

  // read capture at the rising edge of the read strobe
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      o_rd_valid   <= 1'b0;
      o_rd_data    <= 8'h00;
      o_rd_status  <= 1'b0;
      o_rpix_valid <= 1'b0;
      o_rpix_data  <= '0;
      racc         <= '0;
    end else begin
      o_rd_valid   <= rd_done && (mode != MODE_RD);
      o_rpix_valid <= rd_done && (mode == MODE_RD) && rpix_emit;
      if (rd_done && (mode != MODE_RD)) begin
        o_rd_data   <= data_s2[7:0];
        o_rd_status <= is_status(last_cmd);
      end
      if (rd_done && (mode == MODE_RD)) begin
        racc <= next_racc;
        if (rpix_emit) o_rpix_data <= rpix_word;
      end
    end
  end

  // checks on the pin protocol and the packing
  AST_CMD_LOW8: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (!o_write_strobe_n && !o_data_command_select) |-> (o_data[23:8] == 16'h0))
    else $error("command drove lines above 7");
  AST_WR_FRAME: assert property (@(posedge i_core_clk) disable iff (i_reset)
    $fell(o_write_strobe_n) |-> o_read_strobe_n && o_data_oe &&
    $stable(o_data_command_select) && $stable(o_data))
    else $error("write strobe fell without stable setup");
  AST_RD_LOW: assert property (@(posedge i_core_clk) disable iff (i_reset)
    $fell(o_read_strobe_n) |-> (!o_read_strobe_n && !o_data_oe) [*5]
    ##1 o_read_strobe_n)
    else $error("read strobe low time wrong");
  AST_RD_CAPTURE: assert property (@(posedge i_core_clk) disable iff (i_reset)
    ($rose(o_read_strobe_n) && (mode != MODE_RD)) |->
    o_rd_valid && (o_rd_data == $past(data_s2[7:0])))
    else $error("read data not captured at strobe rise");
  AST_SELECT: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (!o_write_strobe_n || !o_read_strobe_n) |-> !o_port_select_n)
    else $error("strobe outside port select");
  AST_STRAPS: assert property (@(posedge i_core_clk) disable iff (i_reset)
    1'b1 |=> ({o_bus_select_strap3, o_bus_select_strap2, o_bus_select_strap1,
               o_bus_select_strap0} == $past(i_bus_code)))
    else $error("straps do not follow width code");
  AST_P262_W8: assert property (@(posedge i_core_clk) disable iff (i_reset)
    ($fell(o_write_strobe_n) && $past(take_pix, 2) && (width == BUS_W8) &&
     (fmt == FMT_262K)) |-> (o_data[1:0] == 2'b00) &&
     (o_data[23:8] == 16'h0))
    else $error("262K byte uses lines 1..0");
  AST_WIDE565: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (!o_write_strobe_n && (mode == MODE_WR) && (fmt == FMT_65K) &&
     (width >= BUS_W16)) |-> (o_data[23:16] == 8'h00))
    else $error("65K word above line 15");
  AST_GROUP_HOLD: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (i_cmd_valid && (phase != 2'd0) && (mode == MODE_WR)) |-> !o_cmd_ready)
    else $error("command accepted inside pixel group");
  AST_FMT_SET: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (take_cmd && i_cmd_dc && !i_cmd_read && (mode == MODE_FMT)) |=>
    (fmt == $past(i_cmd_data[2:0])) && (mode == MODE_REG))
    else $error("format parameter not taken");

  COV_PIX_WRITE: cover property (@(posedge i_core_clk)
    (mode == MODE_WR) && $fell(o_write_strobe_n));
  COV_STATUS_READ: cover property (@(posedge i_core_clk)
    o_rd_valid && o_rd_status);
  COV_MEM_READ: cover property (@(posedge i_core_clk) o_rpix_valid);
  COV_FIFO_FULL: cover property (@(posedge i_core_clk) !o_pix_ready);
endmodule
`default_nettype wire

// ---- verif/pxp_dev_model.sv ----
// behavioural display device on the far side of the parallel port
// assumes strobes come from the host controller; it has no clock
`timescale 1ns/100ps
`default_nettype none
module pxp_dev_model (
  input  wire logic        i_port_select_n,
  input  wire logic        i_write_strobe_n,
  input  wire logic        i_read_strobe_n,
  input  wire logic        i_data_command_select,
  input  wire logic [23:0] i_data,
  input  wire logic [23:0] i_rd_word,
  output logic      [23:0] o_data
);
  logic [24:0] wr_log[$];  // select level and bus word of each write
  logic [23:0] last;       // last driven word, inverted once released
  initial begin
    o_data = 24'h000000;
    last   = 24'h000000;
  end
  // latch on the rising write strobe, only while selected
  always @(posedge i_write_strobe_n)
    if (!i_port_select_n && i_read_strobe_n)
      wr_log.push_back({i_data_command_select, i_data});
  // bench supplies the whole word as is; the 9-bit read test drives unused line 0 high
  always @(negedge i_read_strobe_n)
    if (!i_port_select_n) begin
      o_data = i_rd_word;
      last   = i_rd_word;
    end
  // released bus shows a changed pattern, never the stale word
  always @(posedge i_read_strobe_n)
    o_data = ~last;
endmodule
`default_nettype wire

// ---- verif/tb.sv ----
// self-checking bench for the parallel pixel port host controller
// assumes the device model answers reads with the word in rdw
`timescale 1ns/100ps
`default_nettype none
module tb;
  import pxp_pkg::*;
  logic        clk, rst, cv, cdc, crd, pv;       // clock, reset, requests
  logic        crdy, prdy, rv, rs, ppv, fe;      // handshakes and flags
  logic        sel_n, wr_n, rd_n, dcs, oe;       // port pins
  logic [3:0]  code, st;                         // width code and straps
  logic [7:0]  cd, rd8;                          // command and read byte
  logic [23:0] pd, rdw, din, dout, rpx;          // pixel and bus words
  int          bad_count, compares;
  pxp_host DUT (.i_core_clk(clk), .i_reset(rst), .i_bus_code(code),
    .i_cmd_valid(cv), .i_cmd_dc(cdc), .i_cmd_read(crd), .i_cmd_data(cd),
    .o_cmd_ready(crdy), .i_pix_valid(pv), .i_pix_data(pd),
    .o_pix_ready(prdy), .o_rd_valid(rv), .o_rd_data(rd8),
    .o_rd_status(rs), .o_rpix_valid(ppv), .o_rpix_data(rpx),
    .o_fmt_error(fe), .o_port_select_n(sel_n), .o_write_strobe_n(wr_n),
    .o_read_strobe_n(rd_n), .o_data_command_select(dcs), .o_data(dout),
    .o_data_oe(oe), .i_data(din), .o_bus_select_strap3(st[3]),
    .o_bus_select_strap2(st[2]), .o_bus_select_strap1(st[1]),
    .o_bus_select_strap0(st[0]));
  pxp_dev_model DEV (.i_port_select_n(sel_n), .i_write_strobe_n(wr_n),
    .i_read_strobe_n(rd_n), .i_data_command_select(dcs), .i_data(dout),
    .i_rd_word(rdw), .o_data(din));
  // four-state compare so an unknown never matches
  task automatic chk(input logic [24:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // width code is static, so each width gets its own reset
  task automatic restart(input logic [3:0] c);
    code <= c;
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    DEV.wr_log.delete();
  endtask
  // request stands until the edge that sees ready
  task automatic req(input logic dc, rd, input logic [7:0] d);
    int n;
    n = 0;
    {cdc, crd, cd, cv} <= {dc, rd, d, 1'b1};
    do @(posedge clk); while (crdy !== 1'b1 && ++n < 50);
    chk(25'(crdy), 25'h1);
    cv <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wait_log(input int n);
    int k;
    k = 0;
    while (DEV.wr_log.size() < n && ++k < 300) @(posedge clk);
  endtask
  // format, memory write, one pixel, then the words seen on the wire
  task automatic pix_run(input logic [3:0] c, input logic [7:0] f,
                         input logic [23:0] e0, e1, input int n);
    restart(c);
    chk(25'(st), 25'(c));
    req(1'b0, 1'b0, CMD_PIX_FORMAT);
    req(1'b1, 1'b0, f);
    req(1'b0, 1'b0, CMD_MEM_WRITE);
    {pd, pv} <= {24'hf1824c, 1'b1};
    do @(posedge clk); while (prdy !== 1'b1);
    pv <= 1'b0;
    wait_log(3 + n);
    chk(DEV.wr_log[0], {17'h0, CMD_PIX_FORMAT});
    chk(DEV.wr_log[1], {17'h10000, f});
    chk(DEV.wr_log[3], {1'b1, e0});
    if (n > 1)
      chk(DEV.wr_log[4], {1'b1, e1});
  endtask
  task automatic t_pixels();
    restart(BUS_W8);
    chk({sel_n, wr_n, rd_n, dcs, oe}, 25'h1e);
    pix_run(BUS_W8, 8'h05, 24'h0000f4, 24'h000009, 2);
    pix_run(BUS_W8, 8'h06, 24'h0000f0, 24'h000080, 2);
    pix_run(BUS_W9, 8'h06, 24'h0001e4, 24'h000013, 2);
    pix_run(BUS_W16, 8'h05, 24'h00f409, 24'h0, 1);
    pix_run(BUS_W18, 8'h07, 24'h00f182, 24'h0, 1);
    pix_run(BUS_W16, 8'h06, 24'h00f080, 24'h0, 1);
    // the group waits for its second pixel, so a command is refused
    cv <= 1'b1;
    repeat (3) @(posedge clk);
    chk(25'(crdy), 25'h0);
    cv <= 1'b0;
    pix_run(BUS_W18, 8'h06, 24'h03c813, 24'h0, 1);
    pix_run(BUS_W24, 8'h07, 24'hf1054c, 24'h0, 1);
    $display("pixel writes done");
  endtask
  // status read on low lines, then one pixel read on all 24 lines
  task automatic t_reads();
    restart(BUS_W24);
    rdw <= 24'h0000a5;
    req(1'b0, 1'b0, CMD_ST_LO);
    req(1'b1, 1'b1, 8'h00);
    repeat (20) if (rv !== 1'b1) @(posedge clk);
    chk(25'(rd8), 25'h0a5);
    chk(25'(rs), 25'h1);
    rdw <= 24'hf1054c;
    req(1'b0, 1'b0, CMD_MEM_READ);
    req(1'b1, 1'b1, 8'h00);
    repeat (20) if (ppv !== 1'b1) @(posedge clk);
    chk(25'(rpx), 25'hf1824c);
    // 9-bit memory read: three reads on lines 8..1, line 0 ignored
    restart(BUS_W9);
    req(1'b0, 1'b0, CMD_MEM_READ);
    rdw <= 24'h0001e3;
    req(1'b1, 1'b1, 8'h00);
    repeat (8) @(posedge clk);
    rdw <= 24'h000104;
    req(1'b1, 1'b1, 8'h00);
    repeat (8) @(posedge clk);
    rdw <= 24'h000098;
    req(1'b1, 1'b1, 8'h00);
    repeat (20) if (ppv !== 1'b1) @(posedge clk);
    chk(25'(rpx), 25'hf1824c);
    $display("reads done");
  endtask
  // a bad format holds pixels, so the fifo fills; a good one drains it
  task automatic t_fifo();
    int k;
    k = 0;
    restart(BUS_W8);
    req(1'b0, 1'b0, CMD_PIX_FORMAT);
    req(1'b1, 1'b0, 8'h03);
    req(1'b0, 1'b0, CMD_MEM_WRITE);
    {pd, pv} <= {24'h123456, 1'b1};
    repeat (14) begin
      @(posedge clk);
      k += int'(prdy === 1'b1);
    end
    pv <= 1'b0;
    chk(25'(k), 25'(FIFO_DEPTH));
    chk({24'(DEV.wr_log.size()), fe}, 25'h7);
    req(1'b0, 1'b0, CMD_PIX_FORMAT);
    req(1'b1, 1'b0, 8'h07);
    req(1'b0, 1'b0, CMD_MEM_WRITE);
    wait_log(30);
    chk(DEV.wr_log[6], 25'h1000012);
    chk(DEV.wr_log[29], 25'h1000056);
    $display("fifo done");
  endtask
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    {cv, cdc, crd, pv, cd, pd, rdw, code} = '0;
    rst = 1'b1;
    t_pixels();
    t_reads();
    t_fifo();
    summarize();
  end
  // cut a hang short well after the tests should be over
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    summarize();
  end
endmodule
`default_nettype wire
